// ### alarm_low_limit_and_cmd_echo.sv
// Serial program space: per-channel low alarm limits and command echo
`timescale 1ns/1ps
`include "alarm_low_limit_regs.svh"

module alarm_low_limit_and_cmd_echo #(
    parameter int NUM_CH = 8
) (
    input  wire logic                 i_clock,
    input  wire logic                 i_srst,
    input  wire logic                 i_cs_n,
    input  wire logic                 i_sclk,
    input  wire logic                 i_sdi,
    output logic                      o_sdo,
    output logic [NUM_CH*14-1:0]      o_low_limit
);

    // ----------------------------------------
    // Serial framing
    // ----------------------------------------
    alarm_low_limit_pkg::serial_state_t s_q;
    alarm_low_limit_pkg::serial_state_t s_d;

    logic        sclk_rise;
    logic        sclk_fall;
    logic        frame_end;
    logic        cmd_exec;
    logic [15:0] cmd_full;
    logic [6:0]  cmd_addr;
    logic        cmd_write;
    logic [7:0]  cmd_data;
    logic [7:0]  read_data;
    logic [7:0]  upper_q [NUM_CH];
    logic [7:0]  lower_q [NUM_CH];

    assign sclk_rise = !i_cs_n && i_sclk && !s_q.sclk_prev;
    assign sclk_fall = !i_cs_n && !i_sclk && s_q.sclk_prev;
    assign frame_end = i_cs_n && !s_q.cs_n_prev;
    // Commands act on the sixteenth rising edge, not at frame end, so the read
    // data is ready before the sixteenth falling edge.
    assign cmd_exec  = sclk_rise && (s_q.bit_count == `CMD_LAST_BIT);
    assign cmd_full  = {s_q.cmd_shift[14:0], i_sdi};
    assign cmd_addr  = cmd_full[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
    assign cmd_write = cmd_full[`CMD_WRITE_BIT];
    assign cmd_data  = cmd_full[7:0];

    always_comb begin
        read_data = 8'h00;
        if (cmd_addr == `CMD_ECHO_ADDR) begin
            read_data = s_q.echo;
        end else begin
            for (int n = 0; n < NUM_CH; n++) begin
                if (cmd_addr == 7'(`LOW_LIMIT_UPPER_CH0 + n * `LOW_LIMIT_CH_STRIDE)) begin
                    read_data = upper_q[n];
                end else if (cmd_addr == 7'(`LOW_LIMIT_LOWER_CH0 + n * `LOW_LIMIT_CH_STRIDE)) begin
                    read_data = lower_q[n];
                end
            end
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.sclk_prev = i_sclk;
        s_d.cs_n_prev = i_cs_n;
        if (i_cs_n) begin
            s_d.bit_count = 6'h00;
            s_d.sdo       = 1'b0;
            s_d.tx_shift  = 16'h0000;
        end else if (sclk_rise) begin
            s_d.cmd_shift = cmd_full;
            if (s_q.bit_count != `BIT_COUNT_MAX) begin
                s_d.bit_count = s_q.bit_count + 6'd1;
            end
        end else if (sclk_fall && s_q.bit_count >= `CMD_BITS) begin
            s_d.sdo      = s_q.tx_shift[15];
            s_d.tx_shift = {s_q.tx_shift[14:0], 1'b0};
        end
        if (cmd_exec) begin
            // Writes return zeros; only reads place data on the line
            s_d.tx_shift     = cmd_write ? 16'h0000 : {read_data, 8'h00};
            s_d.echo_pending = cmd_full[15:8];
            s_d.echo_valid   = 1'b1;
        end
        // Echo updates only when the frame closes, so a read sees the prior frame
        if (frame_end) begin
            if (s_q.echo_valid) begin
                s_d.echo = s_q.echo_pending;
            end
            s_d.echo_valid = 1'b0;
        end
        if (i_srst) begin
            s_d = '0;
            s_d.sclk_prev = 1'b0;
            s_d.cs_n_prev = 1'b1;
            s_d.echo      = `ECHO_RESET;
        end
    end

    always_ff @(posedge i_clock) begin
        s_q <= s_d;
    end

    assign o_sdo = s_q.sdo;

    // ----------------------------------------
    // Per-channel limit registers
    // ----------------------------------------
    for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
        localparam logic [6:0] UPPER_ADDR = 7'(`LOW_LIMIT_UPPER_CH0 + n * `LOW_LIMIT_CH_STRIDE);
        localparam logic [6:0] LOWER_ADDR = 7'(`LOW_LIMIT_LOWER_CH0 + n * `LOW_LIMIT_CH_STRIDE);
        logic [7:0] up_q;
        logic [7:0] lo_q;

        always_ff @(posedge i_clock) begin
            if (i_srst) begin
                up_q <= `LIMIT_RESET;
                lo_q <= `LIMIT_RESET;
            end else if (cmd_exec && cmd_write) begin
                if (cmd_addr == UPPER_ADDR) begin
                    up_q <= cmd_data;
                end else if (cmd_addr == LOWER_ADDR) begin
                    lo_q <= cmd_data & `LOWER_FIELD_MASK;
                end
            end
        end

        assign upper_q[n] = up_q;
        assign lower_q[n] = lo_q;
        assign o_low_limit[n*14 +: 14] = {up_q, lo_q[7:2]};

        AST_LOWER_ZERO: assert property (@(posedge i_clock) disable iff (i_srst)
            lo_q[1:0] == 2'b00)
            else $error("Low limit reserved bits nonzero");

        // Each pair answers only at its own address
        AST_CH_UPPER_WRITE: assert property (@(posedge i_clock) disable iff (i_srst)
            cmd_exec && cmd_write && cmd_addr == UPPER_ADDR |=> up_q == $past(cmd_data))
            else $error("Channel upper byte not written at its own address");
        AST_CH_LOWER_WRITE: assert property (@(posedge i_clock) disable iff (i_srst)
            cmd_exec && cmd_write && cmd_addr == LOWER_ADDR |=> lo_q[7:2] == $past(cmd_data[7:2]))
            else $error("Channel lower bits not written at their own address");
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_echo_read;
        cmd_exec && !cmd_write && cmd_addr == `CMD_ECHO_ADDR;
    endsequence

    sequence s_ch0_upper_write;
        cmd_exec && cmd_write && cmd_addr == `LOW_LIMIT_UPPER_CH0;
    endsequence

    sequence s_ch0_lower_write;
        cmd_exec && cmd_write && cmd_addr == `LOW_LIMIT_LOWER_CH0;
    endsequence

    sequence s_echo_write;
        cmd_exec && cmd_write && cmd_addr == `CMD_ECHO_ADDR;
    endsequence

    sequence s_ch0_upper_read;
        cmd_exec && !cmd_write && cmd_addr == `LOW_LIMIT_UPPER_CH0;
    endsequence

    AST_RESET_CLEARS: assert property (@(posedge i_clock) i_srst |=>
        upper_q[0] == 8'h00 && lower_q[0] == 8'h00 && s_q.echo == 8'h00)
        else $error("Reset did not clear registers");
    AST_UPPER_WRITE: assert property (@(posedge i_clock) disable iff (i_srst)
        s_ch0_upper_write |=> upper_q[0] == $past(cmd_data))
        else $error("Channel zero upper byte not written");
    AST_LOWER_WRITE: assert property (@(posedge i_clock) disable iff (i_srst)
        s_ch0_lower_write |=> lower_q[0] == ($past(cmd_data) & 8'hfc))
        else $error("Channel zero lower bits not written");
    AST_ECHO_LOAD: assert property (@(posedge i_clock) disable iff (i_srst)
        s_echo_read |=> s_q.tx_shift == {$past(s_q.echo), 8'h00})
        else $error("Echo read loaded wrong word");
    AST_SDO_QUIET: assert property (@(posedge i_clock) disable iff (i_srst)
        s_q.bit_count < `CMD_BITS |-> o_sdo == 1'b0)
        else $error("SDO driven before sixteenth falling edge");
    AST_FIRST_BIT: assert property (@(posedge i_clock) disable iff (i_srst)
        sclk_fall && s_q.bit_count == `CMD_BITS |=> o_sdo == $past(s_q.tx_shift[15]))
        else $error("First echo bit not on sixteenth falling edge");
    AST_ZERO_TAIL: assert property (@(posedge i_clock) disable iff (i_srst)
        sclk_fall && s_q.bit_count >= `ECHO_USEFUL_END |=> o_sdo == 1'b0)
        else $error("Echo tail bits not zero");
    AST_ECHO_UPDATE: assert property (@(posedge i_clock) disable iff (i_srst)
        frame_end && s_q.echo_valid |=> s_q.echo == $past(s_q.echo_pending))
        else $error("Echo not updated at frame end");
    AST_ECHO_HOLD: assert property (@(posedge i_clock) disable iff (i_srst)
        !frame_end |=> $stable(s_q.echo))
        else $error("Echo changed mid frame");
    // Limits only move on a command; a stray edge must never retune an alarm
    AST_RESET_OUTPUTS: assert property (@(posedge i_clock) i_srst |=>
        o_sdo == 1'b0 && o_low_limit == '0)
        else $error("Reset did not clear outputs");
    AST_LIMIT_HOLD: assert property (@(posedge i_clock) disable iff (i_srst)
        !cmd_exec |=> $stable(o_low_limit))
        else $error("Limit changed without a command");
    AST_ECHO_READ_ONLY: assert property (@(posedge i_clock) disable iff (i_srst)
        s_echo_write |=> $stable(o_low_limit) && s_q.tx_shift == 16'h0000)
        else $error("Write to echo address had an effect");
    AST_UPPER_READ: assert property (@(posedge i_clock) disable iff (i_srst)
        s_ch0_upper_read |=> s_q.tx_shift == {$past(upper_q[0]), 8'h00})
        else $error("Channel zero upper byte read loaded wrong word");
    AST_SDO_IDLE: assert property (@(posedge i_clock) disable iff (i_srst)
        i_cs_n |=> o_sdo == 1'b0)
        else $error("SDO driven outside a frame");
    AST_SHORT_FRAME: assert property (@(posedge i_clock) disable iff (i_srst)
        frame_end && !s_q.echo_valid |=> $stable(s_q.echo))
        else $error("Echo changed after a frame that executed nothing");

endmodule

// ### alarm_low_limit_and_cmd_echo_tb.sv
// Self-checking bench for the low limit bank and command echo
`timescale 1ns/1ps
`include "alarm_low_limit_regs.svh"

module alarm_low_limit_and_cmd_echo_tb;
    logic         i_clock;
    logic         i_srst;
    logic         cs_n, sclk, sdi, sdo;
    logic [111:0] low_limit;
    logic [15:0]  seed, rd;
    logic [7:0]   up [8];
    logic [7:0]   lw [8];
    logic [7:0]   prev;
    int           error_cnt = 0;
    int           n_tests = 0;

    alarm_low_limit_and_cmd_echo #(.NUM_CH(8)) dut_u (.i_clock(i_clock), .i_srst(i_srst),
        .i_cs_n(cs_n), .i_sclk(sclk), .i_sdi(sdi), .o_sdo(sdo), .o_low_limit(low_limit));
    spi_host_model host_u (.i_clock(i_clock), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi),
        .i_sdo(sdo));

    // ----
    // Helpers
    // ----
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic do_reset;
        @(posedge i_clock) i_srst <= 1'h1;
        repeat (20) @(posedge i_clock);
        i_srst <= 1'h0;
        prev = 8'h00;
        for (int c = 0; c < 8; c++) begin
            up[c] = 8'h00;
            lw[c] = 8'h00;
        end
    endtask
    // Model decodes pairs at 18h plus stride per channel
    task automatic op(input logic [6:0] addr, input logic wr, input logic [7:0] data);
        int a;
        int n;
        int k;
        int len;
        logic [15:0] exp;
        a = int'(addr) - 'h18;
        n = (a >= 0) ? a / `LOW_LIMIT_CH_STRIDE : 8;
        k = (a >= 0) ? a % `LOW_LIMIT_CH_STRIDE : 4;
        len = (addr == 7'h3f && !wr && data[0]) ? 24 : 32;
        host_u.xfer({addr, wr, data}, len, rd);
        exp = 16'h0000;
        if (addr == 7'h3f) exp = {prev, 8'h00};
        else if (n < 8 && k == 0) exp = {up[n], 8'h00};
        else if (n < 8 && k == 1) exp = {lw[n], 8'h00};
        if (!wr) check(rd, exp);
        if (wr && n < 8 && k == 0) up[n] = data;
        if (wr && n < 8 && k == 1) lw[n] = data & 8'hfc;
        prev = {addr, wr};
        for (int c = 0; c < 8; c++) begin
            check({2'h0, low_limit[c*14+:14]}, {2'h0, up[c], lw[c][7:2]});
        end
    endtask

    // ----
    // Sequence
    // ----
    initial begin
        i_clock = 1'h0;
        forever #20 i_clock = ~i_clock;
    end
    initial begin
        i_srst = 1'h1;
        seed   = 16'hd743;
        do_reset();
        op(7'h3f, 1'h0, 8'h00);
        op(7'h18, 1'h1, 8'haa);
        op(7'h19, 1'h1, 8'hff);
        op(7'h3f, 1'h1, 8'h55);
        op(7'h19, 1'h0, 8'h00);
        op(7'h18, 1'h0, 8'h00);
        host_u.xfer(16'h33ff, 8, rd);
        op(7'h3f, 1'h0, 8'h01);
        for (int t = 0; t < 60; t++) begin
            seed = lfsr(seed);
            case (seed[4:3])
                2'h0: op(7'(7'h18 + 5 * seed[2:0]), seed[5], seed[15:8]);
                2'h1: op(7'(7'h19 + 5 * seed[2:0]), seed[5], seed[15:8]);
                2'h2: op(7'h3f, seed[5], seed[15:8]);
                default: op({2'h1, seed[13:9]}, seed[5], seed[15:8]);
            endcase
        end
        do_reset();
        op(7'h3f, 1'h0, 8'h00);
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge i_clock);
        error_cnt++;
        end_of_test();
    end
endmodule

// ### alarm_low_limit_pkg.sv
// Types shared by the low limit bank
package alarm_low_limit_pkg;

    typedef struct packed {
        logic        sclk_prev;
        logic        cs_n_prev;
        logic [5:0]  bit_count;
        logic [15:0] cmd_shift;
        logic [15:0] tx_shift;
        logic        sdo;
        logic [7:0]  echo_pending;
        logic        echo_valid;
        logic [7:0]  echo;
    } serial_state_t;

endpackage

// ### alarm_low_limit_regs.svh
// Offsets, field positions, reset values and frame counts of the low limit bank
`ifndef ALARM_LOW_LIMIT_REGS_SVH
`define ALARM_LOW_LIMIT_REGS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define LOW_LIMIT_UPPER_CH0  7'h18
`define LOW_LIMIT_LOWER_CH0  7'h19
`define LOW_LIMIT_CH_STRIDE  7'h05
`define CMD_ECHO_ADDR        7'h3f

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define LOWER_FIELD_MASK     8'hfc
`define LIMIT_RESET          8'h00
`define ECHO_RESET           8'h00

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define CMD_ADDR_MSB         15
`define CMD_ADDR_LSB         9
`define CMD_WRITE_BIT        8
`define CMD_BITS             6'd16
`define CMD_LAST_BIT         6'd15
`define ECHO_USEFUL_END      6'd24
`define BIT_COUNT_MAX        6'h3f

`endif

// ### spi_host_model.sv
// Serial host model that frames commands and captures the reply
`timescale 1ns/1ps

module spi_host_model (
    input  wire logic i_clock,
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_sdi,
    input  wire logic i_sdo
);
    // ----
    // Frame
    // ----
    initial begin
        o_cs_n = 1'h1;
        o_sclk = 1'h0;
        o_sdi  = 1'h0;
    end
    // Frame length: 24 cuts an echo short, 32 shows the zero tail, below 16 runs nothing
    task automatic xfer(input logic [15:0] cmd, input int len, output logic [15:0] rd);
        rd = 16'h0000;
        for (int i = 0; i < len; i++) begin
            @(posedge i_clock) o_sclk <= 1'h0;
            o_cs_n <= 1'h0;
            o_sdi  <= (i < 16) ? cmd[15-i] : ~o_sdi;
            repeat (2) @(posedge i_clock);
            @(negedge i_clock) if (i >= 16) rd[31-i] = i_sdo;
            @(posedge i_clock) o_sclk <= 1'h1;
            repeat (2) @(posedge i_clock);
        end
        @(posedge i_clock) o_sclk <= 1'h0;
        o_cs_n <= 1'h1;
        o_sdi  <= ~o_sdi;
        repeat (3) @(posedge i_clock);
    endtask
endmodule
